// File: src/scr_defs.svh
// Purpose: offsets, field positions, reset values of the system control register
// Assumes: included by its bare name from the register module and the testbench
// Notes:   definitions only
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH

`define SCR_ADDR_W       8
`define SCR_OFS_SYSCTRL  8'h00
// field positions
`define SCR_OVR_HI       17
`define SCR_OVR_LO       16
`define SCR_CKS_RES_BIT  15
`define SCR_DBG_EN_BIT   14
`define SCR_CKS_GO_BIT   13
`define SCR_ROM_DONE_BIT 12
`define SCR_EMC_DIS_BIT  9
`define SCR_SRAM_FL_BIT  7
`define SCR_ICF_BIT      6
`define SCR_SWAP_BIT     4
`define SCR_FIX_HI       3
`define SCR_FIX_LO       1
`define SCR_STRAP_BIT    0
// reset values
`define SCR_OVR_RST      2'h2
`define SCR_FIX_VAL      3'h1
`define SCR_EMC_DIS_RST  1'h1
`define SCR_DBG_EN_RST   1'h0

`endif

// File: src/scr_pkg.sv
// Purpose: types shared by the system control register files
// Assumes: nothing
// Notes:   constants live in scr_defs.svh
`default_nettype none
package scr_pkg;
  typedef logic [31:0] scr_word_t;
  typedef enum {
    SCR_FL_IDLE,
    SCR_FL_REQ,
    SCR_FL_WAIT
  } scr_flush_state_e;
endpackage : scr_pkg
`default_nettype wire

// File: src/scr_flush_if.sv
// Purpose: carries flush control between register file and flush sequencer
// Assumes: single clock domain
// Notes:   regs side starts, ctrl side runs the sequence
`default_nettype none
interface scr_flush_if;
  logic icache_start;
  logic icache_busy;
  logic swap_flag;
  logic swap_flush;
  modport ctrl (input icache_start, output icache_busy, output swap_flag, output swap_flush);
  modport regs (output icache_start, input icache_busy, input swap_flag, input swap_flush);
endinterface : scr_flush_if
`default_nettype wire

// File: src/scr_flush_seq.sv
// Purpose: instruction cache flush sequence and half-swap change detection
// Assumes: cache answers a request with a one-cycle done pulse
// Notes:   a start while busy is absorbed by the flush already running
`default_nettype none
module scr_flush_seq (
  input  wire logic     clk,
  input  wire logic     sys_rst,
  scr_flush_if.ctrl     fl,
  input  wire logic     flash_half_swap,
  input  wire logic     icache_flush_done,
  output logic          icache_flush_req,
  output logic          all_cache_flush
);
  scr_pkg::scr_flush_state_e state_reg;
  scr_pkg::scr_flush_state_e state_next;
  logic                      swap_reg;

  // next state of the flush sequence
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      scr_pkg::SCR_FL_IDLE: begin
        if (fl.icache_start) begin
          state_next = scr_pkg::SCR_FL_REQ;
        end
      end
      scr_pkg::SCR_FL_REQ: begin
        state_next = scr_pkg::SCR_FL_WAIT;
      end
      scr_pkg::SCR_FL_WAIT: begin
        if (icache_flush_done) begin
          state_next = scr_pkg::SCR_FL_IDLE;
        end
      end
      default: begin
        state_next = scr_pkg::SCR_FL_IDLE;
      end
    endcase
  end

  // state register, no path to abort a running flush
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= scr_pkg::SCR_FL_IDLE;
    end else begin
      state_reg <= state_next; // [RULE_10]
    end
  end

  // request pulse to the cache
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      icache_flush_req <= 1'b0;
    end else begin
      icache_flush_req <= (state_next == scr_pkg::SCR_FL_REQ); // [RULE_09]
    end
  end

  // half-swap flag sampling and change-driven flush of every cache
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      swap_reg        <= 1'b0;
      all_cache_flush <= 1'b0;
    end else begin
      swap_reg        <= flash_half_swap; // [RULE_11]
      all_cache_flush <= (flash_half_swap != swap_reg); // [RULE_12]
    end
  end

  assign fl.icache_busy = (state_reg != scr_pkg::SCR_FL_IDLE);
  assign fl.swap_flag   = swap_reg;
  assign fl.swap_flush  = all_cache_flush;
endmodule : scr_flush_seq
`default_nettype wire

// File: src/scr_system_control.sv
// Purpose: system control register with checksum, debug gate and cache controls
// Assumes: single-word register port, read data one cycle after the read strobe
// Notes:   only sys_rst (system or power-on reset) clears the contents
//
// Summary of operation
// RULE_01: override field resets and stays 10; the code resets it to 10, then takes bits 17:16 on each write
// RULE_02: writing one to bit 13 starts checksum
// RULE_03: checksum done clears start, stores result
// RULE_04: result bit: 0 pass, 1 fail
// RULE_05: bit 14 selects debug port enable
// RULE_06: debug bit write blocked when locked
// RULE_07: bit 9 one disables external cache
// RULE_08: writing one to bit 7 flushes SRAM cache
// RULE_09: bit 6 flushes instruction cache, self-clears
// RULE_10: writing zero never aborts instruction flush
// RULE_11: bit 4 shows hardware half-swap flag
// RULE_12: half-swap change flushes all caches
// RULE_13: only system reset clears this register
// RULE_14: one word at base, reserved ignore writes
`default_nettype none
`include "scr_defs.svh"
module scr_system_control (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic [`SCR_ADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [31:0]             reg_rdata,
  input  wire logic                    flash_factory_locked,
  input  wire logic                    debug_lock,
  input  wire logic                    checksum_done,
  input  wire logic                    checksum_fail,
  input  wire logic                    flash_half_swap,
  input  wire logic                    icache_flush_done,
  input  wire logic                    boot_strap,
  output logic                         checksum_start,
  output logic                         debug_port_enable,
  output logic                         ext_mem_cache_disable,
  output logic                         sram_cache_flush,
  output logic                         core_instr_cache_flush,
  output logic                         all_cache_flush,
  output logic      [1:0]              override_field
);
  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic wr_hit;
  logic rd_hit;
  logic debug_unlocked;
  logic cks_busy_reg;
  logic cks_fail_reg;
  logic sram_flush_bit_reg;
  logic strap_reg;
  logic strap_taken_reg;

  scr_flush_if fl ();

  // decode of the single register address
  function automatic logic scr_hit(input logic [`SCR_ADDR_W-1:0] a);
    return a == `SCR_OFS_SYSCTRL;
  endfunction : scr_hit

  assign wr_hit         = reg_wr && scr_hit(reg_addr); // [RULE_14]
  assign rd_hit         = reg_rd && scr_hit(reg_addr);
  assign debug_unlocked = !flash_factory_locked || !debug_lock;

  ////////////////////////////////////////////////////////////////////////////
  // flush sequencer
  scr_flush_seq u_flush (
    .clk               (clk),
    .sys_rst           (sys_rst),
    .fl                (fl.ctrl),
    .flash_half_swap   (flash_half_swap),
    .icache_flush_done (icache_flush_done),
    .icache_flush_req  (core_instr_cache_flush),
    .all_cache_flush   (all_cache_flush)
  );

  // only a written one starts a flush
  assign fl.icache_start = wr_hit && reg_wdata[`SCR_ICF_BIT]; // [RULE_09] [RULE_10]

  ////////////////////////////////////////////////////////////////////////////
  // override field, kept as software writes it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      override_field <= `SCR_OVR_RST; // [RULE_01] [RULE_13]
    end else if (wr_hit) begin
      override_field <= reg_wdata[`SCR_OVR_HI:`SCR_OVR_LO]; // [RULE_01]
    end
  end

  // checksum run: a start wins over a done in the same cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cks_busy_reg   <= 1'b0;
      checksum_start <= 1'b0;
    end else begin
      checksum_start <= wr_hit && reg_wdata[`SCR_CKS_GO_BIT] && !cks_busy_reg; // [RULE_02]
      if (wr_hit && reg_wdata[`SCR_CKS_GO_BIT]) begin
        cks_busy_reg <= 1'b1; // [RULE_02]
      end else if (checksum_done) begin
        cks_busy_reg <= 1'b0; // [RULE_03]
      end
    end
  end

  // result captured at completion
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cks_fail_reg <= 1'b0;
    end else if (cks_busy_reg && checksum_done) begin
      cks_fail_reg <= checksum_fail; // [RULE_03] [RULE_04]
    end
  end

  // debug port gate, write-protected under lock
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      debug_port_enable <= `SCR_DBG_EN_RST;
    end else if (wr_hit && debug_unlocked) begin
      debug_port_enable <= reg_wdata[`SCR_DBG_EN_BIT]; // [RULE_05] [RULE_06]
    end
  end

  // external memory cache disable
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_mem_cache_disable <= `SCR_EMC_DIS_RST; // [RULE_07]
    end else if (wr_hit) begin
      ext_mem_cache_disable <= reg_wdata[`SCR_EMC_DIS_BIT]; // [RULE_07]
    end
  end

  // sram cache flush: stored bit plus one-cycle pulse per written one
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sram_flush_bit_reg <= 1'b0;
      sram_cache_flush   <= 1'b0;
    end else begin
      sram_cache_flush <= wr_hit && reg_wdata[`SCR_SRAM_FL_BIT]; // [RULE_08]
      if (wr_hit) begin
        sram_flush_bit_reg <= reg_wdata[`SCR_SRAM_FL_BIT];
      end
    end
  end

  // boot strap level caught once after reset release
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_reg       <= 1'b0;
      strap_taken_reg <= 1'b0;
    end else if (!strap_taken_reg) begin
      strap_reg       <= boot_strap;
      strap_taken_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path, zero outside the cycle after a hit read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0;
    end else if (rd_hit) begin
      reg_rdata                                <= 32'h0; // [RULE_14]
      reg_rdata[`SCR_OVR_HI:`SCR_OVR_LO]       <= override_field;
      reg_rdata[`SCR_CKS_RES_BIT]              <= cks_fail_reg; // [RULE_04]
      reg_rdata[`SCR_DBG_EN_BIT]               <= debug_port_enable;
      reg_rdata[`SCR_CKS_GO_BIT]               <= cks_busy_reg; // [RULE_03]
      reg_rdata[`SCR_EMC_DIS_BIT]              <= ext_mem_cache_disable;
      reg_rdata[`SCR_SRAM_FL_BIT]              <= sram_flush_bit_reg;
      reg_rdata[`SCR_ICF_BIT]                  <= fl.icache_busy; // [RULE_09]
      reg_rdata[`SCR_SWAP_BIT]                 <= fl.swap_flag; // [RULE_11]
      reg_rdata[`SCR_FIX_HI:`SCR_FIX_LO]       <= `SCR_FIX_VAL;
      reg_rdata[`SCR_STRAP_BIT]                <= strap_reg;
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_hit_read;
    rd_hit ##1 1'b1;
  endsequence

  sequence s_cks_go;
    wr_hit && reg_wdata[`SCR_CKS_GO_BIT] && !cks_busy_reg;
  endsequence

  sequence s_icf_go;
    wr_hit && reg_wdata[`SCR_ICF_BIT] && !fl.icache_busy;
  endsequence

  chk_ovr_write_keep: assert property ( // [RULE_01]
    wr_hit |=> override_field == $past(reg_wdata[`SCR_OVR_HI:`SCR_OVR_LO]))
    else $error("override field did not take the written value");

  chk_cks_start_pulse: assert property ( // [RULE_02]
    s_cks_go |=> checksum_start && cks_busy_reg ##1 !checksum_start)
    else $error("checksum start not a single pulse after write of one");

  chk_cks_zero_noop: assert property ( // [RULE_02]
    wr_hit && !reg_wdata[`SCR_CKS_GO_BIT] && !cks_busy_reg |=> !checksum_start && !cks_busy_reg)
    else $error("writing zero started a checksum");

  chk_cks_done_clear: assert property ( // [RULE_03]
    cks_busy_reg && checksum_done && !(wr_hit && reg_wdata[`SCR_CKS_GO_BIT])
      |=> !cks_busy_reg && cks_fail_reg == $past(checksum_fail))
    else $error("checksum completion not recorded");

  chk_cks_result_read: assert property ( // [RULE_04]
    s_hit_read |-> reg_rdata[`SCR_CKS_RES_BIT] == $past(cks_fail_reg)
                && reg_rdata[`SCR_CKS_GO_BIT] == $past(cks_busy_reg))
    else $error("checksum bits read wrong");

  chk_dbg_write_takes: assert property ( // [RULE_05]
    wr_hit && debug_unlocked |=> debug_port_enable == $past(reg_wdata[`SCR_DBG_EN_BIT]))
    else $error("debug bit write lost while unlocked");

  chk_dbg_lock_hold: assert property ( // [RULE_06]
    wr_hit && !debug_unlocked |=> $stable(debug_port_enable))
    else $error("debug bit changed while locked");

  chk_emc_disable: assert property ( // [RULE_07]
    wr_hit |=> ext_mem_cache_disable == $past(reg_wdata[`SCR_EMC_DIS_BIT]))
    else $error("cache disable bit not written");

  chk_sram_flush: assert property ( // [RULE_08]
    wr_hit && reg_wdata[`SCR_SRAM_FL_BIT] |=> sram_cache_flush)
    else $error("sram flush pulse missing");

  chk_icf_request: assert property ( // [RULE_09]
    s_icf_go |=> fl.icache_busy && core_instr_cache_flush ##1 !core_instr_cache_flush)
    else $error("instruction flush request missing");

  chk_icf_no_abort: assert property ( // [RULE_10]
    fl.icache_busy && !icache_flush_done |=> fl.icache_busy)
    else $error("instruction flush ended without done");

  chk_swap_read: assert property ( // [RULE_11]
    s_hit_read |-> reg_rdata[`SCR_SWAP_BIT] == $past(fl.swap_flag))
    else $error("half-swap flag read wrong");

  chk_swap_flush: assert property ( // [RULE_12]
    $changed(fl.swap_flag) |-> all_cache_flush)
    else $error("half-swap change did not flush caches");

  chk_rsvd_zero: assert property ( // [RULE_14]
    reg_rdata[31:18] == 14'h0 && reg_rdata[12:10] == 3'h0
      && reg_rdata[8] == 1'b0 && reg_rdata[5] == 1'b0)
    else $error("reserved bits read nonzero");

  chk_idle_rdata: assert property ( // [RULE_14]
    !$past(rd_hit) |-> reg_rdata == 32'h0)
    else $error("read data outside the answer cycle");

  // waiting flush meets its done
  sequence s_icf_done;
    fl.icache_busy && icache_flush_done && !core_instr_cache_flush;
  endsequence

  chk_icf_done_clear: assert property ( // [RULE_09]
    s_icf_done |=> !fl.icache_busy)
    else $error("instruction flush bit not cleared after done");

  chk_icf_zero_write: assert property ( // [RULE_10]
    wr_hit && !reg_wdata[`SCR_ICF_BIT] && !fl.icache_busy |=> !fl.icache_busy && !core_instr_cache_flush)
    else $error("writing zero started an instruction flush");

  chk_cks_busy_hold: assert property ( // [RULE_03]
    cks_busy_reg && !checksum_done |=> cks_busy_reg)
    else $error("checksum start bit cleared without completion");

  chk_sram_no_pulse: assert property ( // [RULE_08]
    !(wr_hit && reg_wdata[`SCR_SRAM_FL_BIT]) |=> !sram_cache_flush)
    else $error("sram flush pulse without a written one");

  chk_dbg_only_write: assert property ( // [RULE_06]
    !wr_hit |=> $stable(debug_port_enable))
    else $error("debug bit changed without a write");

  // unmapped traffic leaves every field alone
  chk_unmapped_keep: assert property ( // [RULE_14]
    reg_wr && !wr_hit |=> $stable(override_field) && $stable(ext_mem_cache_disable)
                       && $stable(debug_port_enable) && !checksum_start && !sram_cache_flush)
    else $error("unmapped write changed the register");

  chk_unmapped_read: assert property ( // [RULE_14]
    reg_rd && !rd_hit |=> reg_rdata == 32'h0)
    else $error("unmapped read returned data");

  chk_swap_follow: assert property ( // [RULE_11]
    !$past(sys_rst) |-> fl.swap_flag == $past(flash_half_swap))
    else $error("half-swap flag does not follow hardware");

  chk_swap_pulse_only: assert property ( // [RULE_12]
    fl.swap_flush |-> $changed(fl.swap_flag))
    else $error("cache flush without a half-swap change");

  chk_strap_hold: assert property ( // [RULE_14]
    strap_taken_reg |=> $stable(strap_reg))
    else $error("strap bit changed after capture");
endmodule : scr_system_control
`default_nettype wire

// File: verification/testbench.sv
// Purpose: self-checking bench for the system control register
// Assumes: read data stands only in the cycle after the read strobe
// Notes:   a bench model of every field predicts each readback
`default_nettype none
`include "scr_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, sys_rst, reg_wr, reg_rd;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_val, d;
  logic        flash_factory_locked, debug_lock, checksum_done, checksum_fail;
  logic        flash_half_swap, icache_flush_done, boot_strap;
  logic        checksum_start, debug_port_enable, ext_mem_cache_disable;
  logic        sram_cache_flush, core_instr_cache_flush, all_cache_flush;
  logic [1:0]  override_field;
  logic        m_res, m_dbg, m_go, m_emc, m_sram, m_icf, m_swap, lk, dl;
  logic        p_cks, p_sram, p_icf;
  int          error_cnt, n_compared, cyc;
  localparam logic [7:0] OFS = `SCR_OFS_SYSCTRL;

  scr_system_control u_dut (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flash_factory_locked(flash_factory_locked), .debug_lock(debug_lock),
    .checksum_done(checksum_done), .checksum_fail(checksum_fail),
    .flash_half_swap(flash_half_swap), .icache_flush_done(icache_flush_done),
    .boot_strap(boot_strap), .checksum_start(checksum_start),
    .debug_port_enable(debug_port_enable), .ext_mem_cache_disable(ext_mem_cache_disable),
    .sram_cache_flush(sram_cache_flush), .core_instr_cache_flush(core_instr_cache_flush),
    .all_cache_flush(all_cache_flush), .override_field(override_field)
  );

  ////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: timeout", $time);
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // expected word from the bench model
  function automatic logic [31:0] exp_word();
    logic [31:0] w;
    w = 32'h0;
    w[17:16] = 2'h2;
    w[15] = m_res;
    w[14] = m_dbg;
    w[13] = m_go;
    w[9] = m_emc;
    w[7] = m_sram;
    w[6] = m_icf;
    w[4] = m_swap;
    w[3:1] = 3'h1;
    w[0] = boot_strap;
    return w;
  endfunction : exp_word

  // write image without the self-clearing start bits
  function automatic logic [31:0] wbase();
    return exp_word() & 32'hFFFF_DFBF;
  endfunction : wbase

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // one-cycle write, then sample the pulses it launched
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
    #1;
    p_cks  = checksum_start;
    p_sram = sram_cache_flush;
    p_icf  = core_instr_cache_flush;
  endtask : wr

  // one-cycle read, data taken in the following cycle
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    rd_val = reg_rdata;
  endtask : rd

  task automatic do_reset();
    @(posedge clk);
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    {m_res, m_dbg, m_go, m_emc, m_sram, m_icf} = 6'h04;
    m_swap = flash_half_swap;
  endtask : do_reset

  task automatic tally_and_finish();
    if (error_cnt == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    error_cnt = 0;
    n_compared = 0;
    cyc = 0;
    void'($urandom(8727));
    {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'h4, 8'h00, 32'h0};
    {flash_factory_locked, debug_lock, checksum_done, checksum_fail} = 4'h0;
    {flash_half_swap, icache_flush_done} = 2'h0;
    boot_strap = 1'($urandom);
    do_reset();
    rd(OFS);
    chk(rd_val, exp_word(), "reset word");
    chk({28'h0, debug_port_enable, ext_mem_cache_disable, override_field}, 32'h6, "reset outs");
    // random traffic, first four passes walk every lock combination
    for (int i = 0; i < 28; i++) begin
      d = $urandom;
      d[17:16] = 2'h2;
      d[13] = 1'h0;
      d[6] = 1'h0;
      {lk, dl} = (i < 4) ? 2'(i) : 2'($urandom);
      if (i < 4) d[14] = ~m_dbg;
      @(posedge clk);
      flash_factory_locked <= lk;
      debug_lock <= dl;
      wr(OFS, d);
      if (!(lk && dl)) m_dbg = d[14];
      m_emc = d[9];
      m_sram = d[7];
      chk(32'(p_sram), 32'(d[7]), "sram flush pulse");
      chk(32'({p_cks, p_icf}), 32'h0, "zero writes idle");
      chk(32'({debug_port_enable, ext_mem_cache_disable}), 32'({m_dbg, m_emc}), "outs");
      chk(32'(override_field), 32'h2, "override kept");
      rd(OFS);
      chk(rd_val, exp_word(), "readback");
    end
    // unmapped address is ignored and reads zero
    wr(8'h04, 32'hFFFF_FFFF);
    chk(32'({p_cks, p_sram, p_icf}), 32'h0, "unmapped pulses");
    rd(8'h04);
    chk(rd_val, 32'h0, "unmapped read");
    // checksum run, pass then fail
    for (int j = 0; j < 2; j++) begin
      wr(OFS, wbase() | 32'h0000_2000);
      m_go = 1'h1;
      chk(32'(p_cks), 32'h1, "checksum start");
      rd(OFS);
      chk(rd_val, exp_word(), "checksum busy");
      @(posedge clk);
      checksum_done <= 1'h1;
      checksum_fail <= 1'(j);
      @(posedge clk);
      checksum_done <= 1'h0;
      m_go = 1'h0;
      m_res = 1'(j);
      rd(OFS);
      chk(rd_val, exp_word(), "checksum result");
    end
    // instruction flush survives a zero write
    wr(OFS, wbase() | 32'h0000_0040);
    m_icf = 1'h1;
    chk(32'(p_icf), 32'h1, "icache request");
    wr(OFS, wbase());
    rd(OFS);
    chk(rd_val, exp_word(), "flush not aborted");
    @(posedge clk);
    icache_flush_done <= 1'h1;
    @(posedge clk);
    icache_flush_done <= 1'h0;
    m_icf = 1'h0;
    rd(OFS);
    chk(rd_val, exp_word(), "flush self clear");
    // half-swap toggles each flush all caches once
    for (int j = 0; j < 2; j++) begin
      m_swap = ~m_swap;
      @(posedge clk);
      flash_half_swap <= m_swap;
      @(posedge clk);
      #1;
      chk(32'(all_cache_flush), 32'h1, "swap flush pulse");
      @(posedge clk);
      #1;
      chk(32'(all_cache_flush), 32'h0, "swap pulse width");
      rd(OFS);
      chk(rd_val, exp_word(), "swap flag");
    end
    // second system reset in mid-run restores defaults
    do_reset();
    rd(OFS);
    chk(rd_val, exp_word(), "mid-run reset");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
